/* File: design/dimm_init_parameter_control.sv */
/*
 * per-channel dimm init parameter register with the logic it steers:
 * rank mapping, init reset and cke timing, mrs control-word wrapping,
 * training step sequencing and training read/write spacing.
 * assumes uclk and dclk ticks arrive as count enables on the core clock,
 * and that the dram command path acknowledges each control word.
 */
`timescale 1ns/100ps
`include "dimm_init_map.svh"

// Functional notes
// - population bits pick mapping; zero means default
// - three-module pattern spreads ranks on six selects
// - lone four-rank pattern uses four selects
// - four-rank-plus pattern uses eight selects
// - timing words around mrs when registered, unless skipped
// - inversion words around mrs when registered, unless skipped
// - write strobe training spaced by five-bit field
// - leveling write cas every 16 or 32
// - step timer expiry advances step and reloads, except from the last step, which returns to idle
// - step timeout is two to field, dram clocks
// - cke blocked two to field uncore clocks
// - dram reset held two to field uncore clocks
// - stop-on-fail without auto-restart disable halts instead of advancing
// - step codes idle 000 through 100
module dimm_init_parameter_control
	import dimm_init_pkg::*;
(
	// clock, reset, enable
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	// register port
	input  wire logic        i_reg_wr,
	input  wire logic [31:0] i_reg_wdata,
	output logic      [31:0] o_reg_rdata,
	// clock domain ticks
	input  wire logic        i_uclk_tick,
	input  wire logic        i_dclk_tick,
	// rank mapping
	input  wire logic [2:0]  i_rank,
	output logic      [7:0]  o_cs_sel,
	output logic      [3:0]  o_cke_sel,
	// initialization
	input  wire logic        i_init_start,
	input  wire logic        i_clk_cmd_valid,
	output logic             o_dram_reset_n,
	output logic             o_cke_allowed,
	// mrs control words
	input  wire logic        i_mrs_req,
	input  wire logic        i_cmd_ack,
	output logic             o_cw_valid,
	output cw_kind_t         o_cw_kind,
	// training
	input  wire logic        i_train_start,
	input  wire logic        i_step_done,
	input  wire logic        i_stop_on_fail,
	input  wire logic        i_auto_restart_disable,
	output logic      [2:0]  o_train_step,
	output logic             o_train_halted,
	output logic             o_wr_cas,
	output logic             o_rd_cas
);

	// ----------------------------------------------------------------
	// parameter register
	// ----------------------------------------------------------------
	logic [31:0] reg_q;
	logic        skip_timing_mode_switch;
	logic        skip_addr_inversion_toggle;
	logic        three_module_flag;
	logic        lone_four_rank_flag;
	logic        four_rank_flag;
	logic [4:0]  write_strobe_train_spacing;
	logic        write_leveling_spacing;
	logic        registered_flag;
	logic [4:0]  train_step_timeout;
	logic [4:0]  cke_block_exp;
	logic [4:0]  reset_on_exp;

	assign skip_timing_mode_switch    = reg_q[`F_SKIP_TIMING];
	assign skip_addr_inversion_toggle = reg_q[`F_SKIP_INVERSION];
	assign three_module_flag          = reg_q[`F_THREE_MODULE];
	assign lone_four_rank_flag        = reg_q[`F_LONE_FOUR_RANK];
	assign four_rank_flag             = reg_q[`F_FOUR_RANK];
	assign write_strobe_train_spacing = reg_q[`F_WR_STROBE_HI:`F_WR_STROBE_LO];
	assign write_leveling_spacing     = reg_q[`F_WR_LEVEL_SPACING];
	assign registered_flag            = reg_q[`F_REGISTERED];
	assign train_step_timeout         = reg_q[`F_STEP_TIMEOUT_HI:`F_STEP_TIMEOUT_LO];
	assign cke_block_exp              = reg_q[`F_CKE_BLOCK_HI:`F_CKE_BLOCK_LO];
	assign reset_on_exp               = reg_q[`F_RESET_ON_HI:`F_RESET_ON_LO];
	assign o_reg_rdata                = reg_q;

	always_ff @(posedge i_core_clk) begin
		if (i_reset)
			reg_q <= `PARAM_RESET_VALUE;
		else if (i_ce && i_reg_wr)
			reg_q <= i_reg_wdata & `PARAM_WRITE_MASK;
	end

	// ----------------------------------------------------------------
	// rank mapping
	// ----------------------------------------------------------------
	// illegal mixes of the population bits fall back to the default map
	map_mode_t  map_mode;
	logic [7:0] cs_d;
	logic [3:0] cke_d;

	assign map_mode =
		( three_module_flag && !lone_four_rank_flag && !four_rank_flag) ? MAP_THREE :
		(!three_module_flag &&  lone_four_rank_flag &&  four_rank_flag) ? MAP_LONE_FOUR :
		(!three_module_flag && !lone_four_rank_flag &&  four_rank_flag) ? MAP_FOUR_PLUS :
		MAP_DEFAULT;
	assign cs_d =
		(map_mode == MAP_THREE) ? ((i_rank < 3'h6) ? (8'h01 << i_rank) : 8'h00) :
		(map_mode == MAP_LONE_FOUR) ? (8'h01 << i_rank[1:0]) :
		(8'h01 << i_rank);
	assign cke_d =
		(map_mode == MAP_LONE_FOUR) ? (4'h1 << i_rank[1]) :
		(map_mode == MAP_DEFAULT) ? (4'h1 << i_rank[1:0]) :
		(4'h1 << i_rank[2:1]);

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_cs_sel  <= 8'h00;
			o_cke_sel <= 4'h0;
		end else if (i_ce) begin
			o_cs_sel  <= cs_d;
			o_cke_sel <= cke_d;
		end
	end

	// ----------------------------------------------------------------
	// initialization: reset pulse, then cke block
	// ----------------------------------------------------------------
	pow2_timer_if init_tmr ();
	init_state_t  init_q;
	init_state_t  init_d;
	logic         init_go;

	assign init_go           = i_init_start && ((init_q == IN_IDLE) || (init_q == IN_DONE));
	assign init_tmr.load     = init_go || ((init_q == IN_WAIT_CLK) && i_clk_cmd_valid);
	assign init_tmr.exponent = (init_q == IN_WAIT_CLK) ? cke_block_exp : reset_on_exp;
	assign init_tmr.tick     = i_uclk_tick;

	pow2_timer u_init_timer (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.bus        (init_tmr.tmr)
	);

	always_comb begin
		init_d = init_q;
		unique case (init_q)
			IN_IDLE:      if (init_go) init_d = IN_RESET;
			IN_RESET:     if (init_tmr.expired) init_d = IN_WAIT_CLK;
			IN_WAIT_CLK:  if (i_clk_cmd_valid) init_d = IN_CKE_BLOCK;
			IN_CKE_BLOCK: if (init_tmr.expired) init_d = IN_DONE;
			IN_DONE:      if (init_go) init_d = IN_RESET;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			init_q         <= IN_IDLE;
			o_dram_reset_n <= 1'b1;
			o_cke_allowed  <= 1'b0;
		end else if (i_ce) begin
			init_q         <= init_d;
			o_dram_reset_n <= (init_d != IN_RESET);
			o_cke_allowed  <= (init_d == IN_DONE);
		end
	end

	// ----------------------------------------------------------------
	// mrs wrapping with control words
	// ----------------------------------------------------------------
	// flags are sampled per step, so change them only while idle
	mrs_state_t mrs_q;
	mrs_state_t mrs_d;
	cw_kind_t   kind_d;
	logic       use_inv;
	logic       use_timing;

	assign use_inv    = registered_flag && !skip_addr_inversion_toggle;
	assign use_timing = registered_flag && !skip_timing_mode_switch;
	assign o_cw_valid = (mrs_q != MS_IDLE);

	always_comb begin
		mrs_d = mrs_q;
		unique case (mrs_q)
			MS_IDLE:    if (i_mrs_req)
				mrs_d = use_inv ? MS_INV_OFF : (use_timing ? MS_T3 : MS_MRS);
			MS_INV_OFF: if (i_cmd_ack) mrs_d = use_timing ? MS_T3 : MS_MRS;
			MS_T3:      if (i_cmd_ack) mrs_d = MS_MRS;
			MS_MRS:     if (i_cmd_ack)
				mrs_d = use_timing ? MS_T1 : (use_inv ? MS_INV_ON : MS_IDLE);
			MS_T1:      if (i_cmd_ack) mrs_d = use_inv ? MS_INV_ON : MS_IDLE;
			MS_INV_ON:  if (i_cmd_ack) mrs_d = MS_IDLE;
		endcase
	end

	always_comb begin
		kind_d = CW_NONE;
		unique case (mrs_d)
			MS_IDLE:    kind_d = CW_NONE;
			MS_INV_OFF: kind_d = CW_INV_OFF;
			MS_T3:      kind_d = CW_TIMING_3T;
			MS_MRS:     kind_d = CW_MRS;
			MS_T1:      kind_d = CW_TIMING_1T;
			MS_INV_ON:  kind_d = CW_INV_ON;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			mrs_q     <= MS_IDLE;
			o_cw_kind <= CW_NONE;
		end else if (i_ce) begin
			mrs_q     <= mrs_d;
			o_cw_kind <= kind_d;
		end
	end

	// ----------------------------------------------------------------
	// training step sequencer
	// ----------------------------------------------------------------
	pow2_timer_if step_tmr ();
	train_state_t train_q;
	train_state_t train_d;
	train_state_t train_next;
	logic [2:0]   step_code_d;
	logic         in_step;
	logic         train_go;
	logic         advance;
	logic         stop;

	assign in_step  = (train_q != ST_IDLE) && !o_train_halted;
	assign train_go = i_train_start && ((train_q == ST_IDLE) || o_train_halted);
	assign advance  = in_step && (i_step_done || step_tmr.expired);
	assign stop     = in_step && step_tmr.expired && !i_step_done
		&& i_stop_on_fail && !i_auto_restart_disable;
	assign train_next =
		(train_q == ST_RD)  ? ST_RCV :
		(train_q == ST_RCV) ? ST_WRL :
		(train_q == ST_WRL) ? ST_WRD : ST_IDLE;
	assign train_d = train_go ? ST_RD : ((advance && !stop) ? train_next : train_q);
	assign step_tmr.load     = train_go || (advance && !stop && (train_next != ST_IDLE));
	assign step_tmr.exponent = train_step_timeout;
	assign step_tmr.tick     = i_dclk_tick;
	assign step_code_d =
		(train_d == ST_RD)  ? `STEP_RD_STROBE :
		(train_d == ST_RCV) ? `STEP_RCV_BITLOCK :
		(train_d == ST_WRL) ? `STEP_WR_LEVEL :
		(train_d == ST_WRD) ? `STEP_WR_STROBE : `STEP_IDLE;

	pow2_timer u_step_timer (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.bus        (step_tmr.tmr)
	);

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			train_q        <= ST_IDLE;
			o_train_step   <= `STEP_IDLE;
			o_train_halted <= 1'b0;
		end else if (i_ce) begin
			train_q        <= train_d;
			o_train_step   <= step_code_d;
			o_train_halted <= stop || (o_train_halted && !train_go);
		end
	end

	// ----------------------------------------------------------------
	// training read/write spacing
	// ----------------------------------------------------------------
	// a zero spacing field still leaves one dram clock between commands
	logic [5:0] gap_q;
	logic [5:0] gap_d;
	logic [5:0] gap_len;
	logic       rd_phase_q;
	logic       spacing_on;
	logic       fire;

	assign spacing_on = in_step && ((train_q == ST_WRL) || (train_q == ST_WRD));
	assign gap_len =
		(train_q == ST_WRL) ? (write_leveling_spacing ? `WR_LEVEL_GAP_LONG
			: `WR_LEVEL_GAP_SHORT) :
		((write_strobe_train_spacing == 5'h00) ? 6'h01
			: {1'b0, write_strobe_train_spacing});
	assign fire  = spacing_on && i_dclk_tick && (gap_q == 6'h00);
	assign gap_d =
		!spacing_on ? 6'h00 :
		fire ? (gap_len - 6'h01) :
		(i_dclk_tick && (gap_q != 6'h00)) ? (gap_q - 6'h01) : gap_q;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			gap_q      <= 6'h00;
			rd_phase_q <= 1'b1;
			o_wr_cas   <= 1'b0;
			o_rd_cas   <= 1'b0;
		end else if (i_ce) begin
			gap_q      <= gap_d;
			rd_phase_q <= !spacing_on ? 1'b1
				: ((fire && (train_q == ST_WRD)) ? !rd_phase_q : rd_phase_q);
			o_wr_cas   <= fire && ((train_q == ST_WRL) || !rd_phase_q);
			o_rd_cas   <= fire && (train_q == ST_WRD) && rd_phase_q;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_map_default_cke: assert property (
		(i_ce && map_mode == MAP_DEFAULT) |=> (o_cke_sel == (4'h1 << $past(i_rank[1:0]))))
		else $error("default map cke wrong");
	a_map_three_cs: assert property (
		(i_ce && map_mode == MAP_THREE) |=> (o_cs_sel[7:6] == 2'b00))
		else $error("three module map used upper selects");
	a_map_lone_cs: assert property (
		(i_ce && map_mode == MAP_LONE_FOUR) |=> (o_cs_sel[7:4] == 4'h0))
		else $error("lone four-rank map used upper selects");
	a_map_plus_cs: assert property (
		(i_ce && map_mode == MAP_FOUR_PLUS) |=> (o_cs_sel == (8'h01 << $past(i_rank))))
		else $error("four-rank-plus map select wrong");
	a_init_reset_low: assert property (
		(init_q == IN_RESET) |-> !o_dram_reset_n)
		else $error("dram reset released early");
	a_init_cke_block: assert property (
		(init_q != IN_DONE) |-> !o_cke_allowed)
		else $error("cke allowed before block time");
	a_mrs_timing_back: assert property (
		(i_ce && mrs_q == MS_MRS && i_cmd_ack && use_timing) |=> (o_cw_kind == CW_TIMING_1T))
		else $error("no return to 1T after mrs");
	a_mrs_inv_skip: assert property (
		(i_ce && mrs_q == MS_IDLE && i_mrs_req && !use_inv) |=> (mrs_q != MS_INV_OFF))
		else $error("inversion word sent while skipped");
	a_step_advance: assert property (
		(i_ce && train_q == ST_RD && in_step && step_tmr.expired && !stop && !i_train_start)
		|=> (train_q == ST_RCV) && step_tmr.busy)
		else $error("step expiry did not advance and reload");
	a_step_halt: assert property (
		(i_ce && stop) |=> (o_train_halted && train_q == $past(train_q)))
		else $error("timed-out step did not halt");
	a_step_code: assert property (
		(train_q == ST_WRD) |-> (o_train_step == `STEP_WR_STROBE))
		else $error("write strobe step code wrong");
	a_level_gap: assert property (
		(i_ce && fire && train_q == ST_WRL && !write_leveling_spacing) |=> (gap_q == 6'h0F))
		else $error("leveling gap not 16");

	c_init_done: cover property (init_q == IN_CKE_BLOCK ##1 init_q == IN_DONE);
	c_train_halt: cover property ($rose(o_train_halted));
	c_level_cas: cover property (o_wr_cas && train_q == ST_WRL);
	c_mrs_full: cover property (mrs_q == MS_T1 ##1 mrs_q == MS_INV_ON);

endmodule // dimm_init_parameter_control

/* File: design/dimm_init_map.svh */
/*
 * field positions, write mask, reset value, step codes and timing counts of the
 * dimm init parameter block.
 * assumes it is included by bare name wherever these are needed.
 */
`ifndef DIMM_INIT_MAP_SVH
`define DIMM_INIT_MAP_SVH

// ----------------------------------------------------------------
// register layout
// ----------------------------------------------------------------
`define PARAM_RESET_VALUE     32'h001E_0000
`define PARAM_WRITE_MASK      32'h07FF_FFFF
`define F_SKIP_TIMING         26
`define F_SKIP_INVERSION      25
`define F_THREE_MODULE        24
`define F_LONE_FOUR_RANK      23
`define F_FOUR_RANK           22
`define F_WR_STROBE_HI        21
`define F_WR_STROBE_LO        17
`define F_WR_LEVEL_SPACING    16
`define F_REGISTERED          15
`define F_STEP_TIMEOUT_HI     14
`define F_STEP_TIMEOUT_LO     10
`define F_CKE_BLOCK_HI        9
`define F_CKE_BLOCK_LO        5
`define F_RESET_ON_HI         4
`define F_RESET_ON_LO         0

// ----------------------------------------------------------------
// training step codes
// ----------------------------------------------------------------
`define STEP_IDLE             3'h0
`define STEP_RD_STROBE        3'h1
`define STEP_RCV_BITLOCK      3'h2
`define STEP_WR_LEVEL         3'h3
`define STEP_WR_STROBE        3'h4

// ----------------------------------------------------------------
// timing counts, in dram clocks
// ----------------------------------------------------------------
`define WR_LEVEL_GAP_SHORT    6'h10
`define WR_LEVEL_GAP_LONG     6'h20

`endif

/* File: design/dimm_init_pkg.sv */
/*
 * types of the dimm init parameter block: population mappings,
 * state machine states and control word kinds.
 * assumes nothing beyond a systemverilog compiler.
 */
package dimm_init_pkg;

	typedef enum logic [1:0] {
		MAP_DEFAULT   = 2'h0,
		MAP_THREE     = 2'h1,
		MAP_LONE_FOUR = 2'h2,
		MAP_FOUR_PLUS = 2'h3
	} map_mode_t;

	typedef enum logic [4:0] {
		IN_IDLE      = 5'h01,
		IN_RESET     = 5'h02,
		IN_WAIT_CLK  = 5'h04,
		IN_CKE_BLOCK = 5'h08,
		IN_DONE      = 5'h10
	} init_state_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RD   = 5'h02,
		ST_RCV  = 5'h04,
		ST_WRL  = 5'h08,
		ST_WRD  = 5'h10
	} train_state_t;

	typedef enum logic [5:0] {
		MS_IDLE    = 6'h01,
		MS_INV_OFF = 6'h02,
		MS_T3      = 6'h04,
		MS_MRS     = 6'h08,
		MS_T1      = 6'h10,
		MS_INV_ON  = 6'h20
	} mrs_state_t;

	typedef enum logic [2:0] {
		CW_NONE      = 3'h0,
		CW_INV_OFF   = 3'h1,
		CW_TIMING_3T = 3'h2,
		CW_MRS       = 3'h3,
		CW_TIMING_1T = 3'h4,
		CW_INV_ON    = 3'h5
	} cw_kind_t;

endpackage

/* File: design/pow2_timer_if.sv */
/*
 * carrier between the parameter block and its power-of-two timers.
 * assumes the controller side drives load, exponent and tick.
 */
`timescale 1ns/100ps

interface pow2_timer_if;
	logic       load;
	logic [4:0] exponent;
	logic       tick;
	logic       busy;
	logic       expired;

	modport ctl (output load, output exponent, output tick, input busy, input expired);
	modport tmr (input load, input exponent, input tick, output busy, output expired);
endinterface

/* File: design/pow2_timer.sv */
/*
 * down counter loaded with two to the power of an exponent.
 * assumes tick is a one-cycle count enable of the counting clock.
 */
`timescale 1ns/100ps

module pow2_timer (
	// clock and reset
	input  wire logic   i_core_clk,
	input  wire logic   i_reset,
	input  wire logic   i_ce,
	// timer control
	pow2_timer_if.tmr   bus
);
	logic [31:0] cnt_q;
	logic        expired_q;
	logic [31:0] load_val;
	logic        last_tick;

	assign load_val    = 32'h0000_0001 << bus.exponent;
	assign last_tick   = bus.tick && (cnt_q == 32'h0000_0001);
	assign bus.busy    = (cnt_q != 32'h0000_0000);
	assign bus.expired = expired_q;

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			cnt_q     <= 32'h0000_0000;
			expired_q <= 1'b0;
		end else if (i_ce) begin
			expired_q <= !bus.load && last_tick;
			if (bus.load)
				cnt_q <= load_val;
			else if (bus.tick && bus.busy)
				cnt_q <= cnt_q - 32'h0000_0001;
		end
	end

	a_timer_load_value: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_ce && bus.load) |=> (cnt_q == (32'h0000_0001 << $past(bus.exponent))))
		else $error("timer did not load two to the exponent");
	a_timer_expire_end: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$rose(expired_q) |-> (cnt_q == 32'h0000_0000))
		else $error("timer expired with count left");

endmodule // pow2_timer

/* File: dv/cmd_path_model.sv */
/*
 * behavioural dram command path: acknowledges each control word.
 * assumes words are presented as a level held until acknowledged.
 */
`timescale 1ns/100ps

module cmd_path_model (
	// clock
	input  wire logic i_core_clk,
	// control word side
	input  wire logic i_cw_valid,
	input  wire logic i_slow,
	output logic      o_cmd_ack
);
	int wait_q = 0;

	// slow mode holds each word at least four cycles, so the block must not advance early
	always @(negedge i_core_clk) begin
		if (o_cmd_ack || i_cw_valid !== 1'b1) begin
			o_cmd_ack <= 1'b0;
			wait_q    <= 0;
		end else if (wait_q >= (i_slow ? 3 : 0))
			o_cmd_ack <= 1'b1;
		else
			wait_q <= wait_q + 1;
	end
endmodule // cmd_path_model

/* File: dv/tb.sv */
/*
 * self-checking bench of the dimm init parameter block.
 * assumes the command path model acknowledges every control word.
 */
`timescale 1ns/100ps

module tb;
	import dimm_init_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        i_core_clk   = 1'b0;
	logic        i_reset      = 1'b1;
	logic        i_reg_wr     = 1'b0;
	logic [31:0] i_reg_wdata  = 32'h0;
	logic        i_uclk_tick  = 1'b1;
	logic        i_dclk_tick  = 1'b1;
	logic        i_ce         = 1'b1;
	logic [2:0]  i_rank       = 3'h0;
	logic        i_init_start = 1'b0;
	logic        i_clk_ok     = 1'b0;
	logic        i_mrs_req    = 1'b0;
	logic        i_train      = 1'b0;
	logic        i_step_done  = 1'b0;
	logic        i_sof        = 1'b0;
	logic        i_ad         = 1'b0;
	logic        slow         = 1'b0;
	logic        half         = 1'b0;
	logic        cmd_ack;
	logic [31:0] rdata;
	logic [31:0] v;
	logic [7:0]  cs;
	logic [3:0]  cke;
	logic        rst_n;
	logic        cke_ok;
	logic        cw_valid;
	logic        halted;
	logic        wr_cas;
	logic        rd_cas;
	cw_kind_t    cw_kind;
	logic [2:0]  step;
	logic [2:0]  pops [4] = '{3'h4, 3'h3, 3'h1, 3'h0};
	int          mismatches = 0;
	int          cmp_count  = 0;
	int          n;
	int          w;
	int          exp_q [$];
	int          seen_q [$];

	dimm_init_parameter_control i_dimm_init_parameter_control (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
		.i_uclk_tick(i_uclk_tick), .i_dclk_tick(i_dclk_tick),
		.i_rank(i_rank), .o_cs_sel(cs), .o_cke_sel(cke),
		.i_init_start(i_init_start), .i_clk_cmd_valid(i_clk_ok),
		.o_dram_reset_n(rst_n), .o_cke_allowed(cke_ok),
		.i_mrs_req(i_mrs_req), .i_cmd_ack(cmd_ack), .o_cw_valid(cw_valid),
		.o_cw_kind(cw_kind), .i_train_start(i_train), .i_step_done(i_step_done),
		.i_stop_on_fail(i_sof), .i_auto_restart_disable(i_ad), .o_train_step(step),
		.o_train_halted(halted), .o_wr_cas(wr_cas), .o_rd_cas(rd_cas));

	cmd_path_model i_cmd_path_model (
		.i_core_clk(i_core_clk), .i_cw_valid(cw_valid), .i_slow(slow), .o_cmd_ack(cmd_ack));

	always #10 i_core_clk = ~i_core_clk;
	// half rate ticks prove the timers count ticks, not core cycles
	always @(negedge i_core_clk) begin
		i_uclk_tick <= half ? ~i_uclk_tick : 1'b1;
		i_dclk_tick <= half ? ~i_dclk_tick : 1'b1;
	end
	always @(posedge i_core_clk) if (cw_valid === 1'b1 && cmd_ack === 1'b1) seen_q.push_back(int'(cw_kind));

	// ----------------------------------------------------------------
	// tasks and model
	// ----------------------------------------------------------------
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %0h seen %0h", what, e, g);
		end
	endtask

	task automatic wr_reg(input logic [31:0] d);
		@(negedge i_core_clk) begin i_reg_wr = 1'b1; i_reg_wdata = d; end
		@(negedge i_core_clk) i_reg_wr = 1'b0;
	endtask

	task automatic pulse(input int which);
		@(negedge i_core_clk);
		case (which) 0: i_init_start = 1; 1: i_mrs_req = 1; 2: i_train = 1; default: i_step_done = 1; endcase
		@(negedge i_core_clk);
		{i_init_start, i_mrs_req, i_train, i_step_done} = 4'h0;
	endtask

	task automatic reset_dut;
		@(negedge i_core_clk) i_reset = 1'b1;
		repeat (3) @(negedge i_core_clk);
		i_reset = 1'b0;
	endtask

	task automatic gap(input bit from_rd, output int k);
		for (k = 0; k < 200 && (from_rd ? rd_cas : wr_cas) !== 1'b1; k++) @(negedge i_core_clk);
		k = 0;
		do begin @(negedge i_core_clk); k++; end while (k < 200 && wr_cas !== 1'b1);
	endtask

	function automatic logic [11:0] map_model(logic [2:0] p, int r);
		logic [7:0] c;
		logic [3:0] k;
		c = 8'h01 << r;
		k = 4'h1 << (r / 2);
		case (p)
			3'h4: c = (r < 6) ? c : 8'h00;
			3'h3: begin c = 8'h01 << (r % 4); k = 4'h1 << ((r / 2) % 2); end
			3'h1: ;
			default: k = 4'h1 << (r % 4);
		endcase
		return {k, c};
	endfunction

	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_core_clk);
		mismatches++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		n = $urandom(37);
		reset_dut();
		cmp("param reset", 32'h001E_0000, rdata);
		repeat (4) begin
			v = $urandom;
			wr_reg(v);
			cmp("param reg", v & 32'h07FF_FFFF, rdata);
		end
		// a low enable must hold the register against a write
		@(negedge i_core_clk) i_ce = 1'b0;
		wr_reg(~v);
		cmp("frozen reg", v & 32'h07FF_FFFF, rdata);
		i_ce = 1'b1;
		// only legal populations; mixed patterns fall back to the default map
		foreach (pops[i]) begin
			wr_reg({7'h0, pops[i], 22'h0});
			for (int r = 0; r < 8; r++) begin
				i_rank = r[2:0];
				@(negedge i_core_clk);
				cmp("rank map", map_model(pops[i], r), {cke, cs});
			end
		end
		for (int c = 0; c < 5; c++) begin
			v = (c < 4) ? 32'h0000_8000 : 32'h0;
			v[26] = c[1];
			v[25] = c[0];
			wr_reg(v);
			slow = c[0];
			exp_q = {};
			seen_q = {};
			if (v[15] && !v[25]) exp_q.push_back(1);
			if (v[15] && !v[26]) exp_q.push_back(2);
			exp_q.push_back(3);
			if (v[15] && !v[26]) exp_q.push_back(4);
			if (v[15] && !v[25]) exp_q.push_back(5);
			pulse(1);
			cmp("cw valid", 1, cw_valid);
			for (n = 0; n < 60 && cw_valid !== 1'b0; n++) @(negedge i_core_clk);
			cmp("cw count", exp_q.size(), seen_q.size());
			foreach (exp_q[j]) cmp("cw kind", exp_q[j], seen_q[j]);
			cmp("cw idle", 0, cw_kind);
		end
		wr_reg(32'h0000_0043);
		half = 1'b1;
		pulse(0);
		for (n = 0; n < 80 && rst_n !== 1'b1; n++) @(negedge i_core_clk);
		cmp("reset span in range", 1, n >= 14 && n <= 20);
		cmp("cke held", 0, cke_ok);
		i_clk_ok = 1'b1;
		for (n = 0; n < 80 && cke_ok !== 1'b1; n++) @(negedge i_core_clk);
		cmp("cke span in range", 1, n >= 6 && n <= 12);
		half = 1'b0;
		reset_dut();
		wr_reg(32'h0000_2800);
		pulse(2);
		for (int s = 1; s < 6; s++) begin
			cmp("train step", s % 5, step);
			if (s < 5) pulse(3);
		end
		for (int m = 0; m < 3; m++) begin
			half = (m == 0);
			reset_dut();
			wr_reg(32'h0000_0C00);
			i_sof = (m > 0);
			i_ad = (m == 1);
			pulse(2);
			for (n = 0; n < 40 && step === 3'h1 && halted !== 1'b1; n++) @(negedge i_core_clk);
			cmp("timeout span in range", 1,
				half ? (n >= 14 && n <= 20) : (n >= 6 && n <= 11));
			cmp("halted", m == 2, halted);
			cmp("step after timeout", (m == 2) ? 1 : 2, step);
		end
		i_sof = 1'b0;
		half = 1'b0;
		for (int b = 0; b < 2; b++) begin
			reset_dut();
			w = 2 + $urandom % 19;
			wr_reg(32'h0000_3000 | (b << 16) | (w << 17));
			pulse(2);
			pulse(3);
			pulse(3);
			gap(1'b0, n);
			cmp("leveling gap", b ? 32 : 16, n);
			pulse(3);
			gap(1'b1, n);
			cmp("strobe gap", w, n);
		end
		stop_test();
	end
endmodule // tb
